//--- rtl/pmic_pkg.sv
// constants and types shared by the proximity measurement and alert logic
package pmic_pkg;

	// ----------------------------------------------------------------
	// register sub-addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CMD = 8'h80;
	localparam logic [7:0] REG_RATE = 8'h82;
	localparam logic [7:0] REG_RES_HI = 8'h87;
	localparam logic [7:0] REG_RES_LO = 8'h88;
	localparam logic [7:0] REG_INT_CTL = 8'h89;
	localparam logic [7:0] REG_THR_LO_HI = 8'h8a;
	localparam logic [7:0] REG_THR_LO_LO = 8'h8b;
	localparam logic [7:0] REG_THR_UP_HI = 8'h8c;
	localparam logic [7:0] REG_THR_UP_LO = 8'h8d;
	localparam logic [7:0] REG_INT_STAT = 8'h8e;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned CMD_SEQ_EN = 0;
	localparam int unsigned CMD_PERIODIC_EN = 1;
	localparam int unsigned CMD_SINGLE_SHOT = 3;
	localparam int unsigned CMD_RESULT_VALID = 5;
	localparam int unsigned CMD_FROZEN = 7;
	localparam int unsigned ICTL_THR_EN = 1;
	localparam int unsigned ICTL_RDY_EN = 3;
	localparam int unsigned ICTL_COUNT_LSB = 5;
	localparam int unsigned STAT_UPPER = 0;
	localparam int unsigned STAT_LOWER = 1;
	localparam int unsigned STAT_READY = 3;
	localparam int unsigned RATE_W = 3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] RATE_RST = 3'h0;
	localparam logic [7:0] INT_CTL_RST = 8'h00;
	localparam logic [15:0] THR_LO_RST = 16'h0000;
	localparam logic [15:0] THR_UP_RST = 16'hffff;
	localparam logic [6:0] DEV_ADDR_RST = 7'h2a; // bus address, value arbitrary
	localparam logic [31:0] LP_BASE_RST = 32'h0002_08d5;

	// ----------------------------------------------------------------
	// serial slave states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SL_IDLE,
		SL_ADDR,
		SL_SUB,
		SL_WDATA,
		SL_ACK,
		SL_READ,
		SL_RACK
	} pmic_slave_st_t;

endpackage

//--- rtl/pmic_sync.sv
// two flip-flop level synchroniser, one lane per bit
module pmic_sync #(
	parameter int unsigned W = 1
) (
	// clock
	input wire logic clk,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} pmic_sync_state_t;

	pmic_sync_state_t s_reg;
	pmic_sync_state_t s_next;

	always_comb
	begin
		s_next.meta = d;
		s_next.stable = s_reg.meta;
	end

	// no reset: the stages refill within two edges
	always_ff @(posedge clk)
	begin
		s_reg <= s_next;
	end

	assign q = s_reg.stable;

endmodule // pmic_sync

//--- rtl/pmic_rate_timer.sv
// self-timed measurement tick generator on the low-power oscillator
module pmic_rate_timer #(
	parameter logic [31:0] LP_BASE_CYCLES = pmic_pkg::LP_BASE_RST
) (
	// low-power clock and main-domain reset
	input wire logic lp_clk,
	input wire logic rst,
	// controls from the main domain
	input wire logic seq_en,
	input wire logic periodic_en,
	input wire logic [2:0] rate,
	// tick event, toggles once per period
	output logic tick_tgl
);

	typedef struct packed {
		logic [2:0] rate;
		logic [31:0] cnt;
		logic tgl;
	} pmic_timer_state_t;

	pmic_timer_state_t q_reg;
	pmic_timer_state_t q_next;
	logic [5:0] lvl;

	pmic_sync #(.W(6)) u_sync (
		.clk(lp_clk),
		.d({rate, rst, periodic_en, seq_en}),
		.q(lvl)
	);

	// rate code 7 is fastest, each lower code doubles the period
	function automatic logic [31:0] period_of(input logic [2:0] r);
		period_of = 32'(LP_BASE_CYCLES << (3'h7 - r));
	endfunction

	always_comb
	begin
		q_next = q_reg;
		// RULE_17: rate sampled only while stopped
		// rate bits only move while the timer is stopped, so lane skew is harmless
		if (!lvl[0])
			q_next.rate = lvl[5:3];
		// RULE_14: runs only when both enables set
		if (lvl[0] && lvl[1])
		begin
			// RULE_13: periodic tick at programmed rate
			if (q_reg.cnt >= period_of(q_reg.rate) - 32'h0000_0001)
			begin
				q_next.cnt = 32'h0000_0000;
				q_next.tgl = ~q_reg.tgl;
			end
			else
				q_next.cnt = q_reg.cnt + 32'h0000_0001;
		end
		else
			q_next.cnt = 32'h0000_0000;
	end

	always_ff @(posedge lp_clk)
	begin
		if (lvl[2])
		begin
			q_reg.rate <= pmic_pkg::RATE_RST;
			q_reg.cnt <= 32'h0000_0000;
			q_reg.tgl <= 1'b0;
		end
		else
			q_reg <= q_next;
	end

	assign tick_tgl = q_reg.tgl;

endmodule // pmic_rate_timer

//--- rtl/pmic_ctrl.sv
// proximity measurement control, threshold filter and alert with serial register slave
//
// Summary of operation
// RULE_01: result below lower or above upper limit is a threshold event.
// RULE_02: an event sets its flag and pulls the alert pin low, never high.
// RULE_03: threshold event only after the programmed run of consecutive hits.
// RULE_04: every completed measurement can raise a data-ready event.
// RULE_05: each condition has an enable; only enabled ones reach the alert.
// RULE_06: each condition latches its own flag; simultaneous events set all flags.
// RULE_07: the host reads the latched flags from the status register.
// RULE_08: host clears a flag by writing one to it; others stay.
// RULE_09: writing all ones to status clears every flag and the alert.
// RULE_10: command register starts measurements, shows result-valid, frozen bit reads one.
// RULE_11: result-valid sets on new result, clears on reading either result byte.
// RULE_12: single-shot bit starts one conversion; result lands high and low bytes.
// RULE_13: periodic enable repeats measurements at the programmed rate.
// RULE_14: sequencer enable starts oscillator; no measurement until periodic enable too.
// RULE_15: host sets sequencer enable before periodic enable.
// RULE_16: single-shot requests are ignored while the sequencer is enabled.
// RULE_17: rate register changes only while the sequencer enable is zero.
// RULE_18: a failing measurement resets the consecutive-hit counter to zero.
// RULE_19: alert stays low while any enabled flag is set.
module pmic_ctrl #(
	parameter logic [6:0] DEV_ADDR = pmic_pkg::DEV_ADDR_RST,
	parameter logic [31:0] LP_BASE_CYCLES = pmic_pkg::LP_BASE_RST
) (
	// clocks and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic lp_clk,
	// serial register bus, open drain data
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// alert pin, open drain
	output logic int_n_o,
	output logic int_n_oe,
	// converter front end
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [15:0] conv_data
);

	typedef struct packed {
		pmic_pkg::pmic_slave_st_t st;
		pmic_pkg::pmic_slave_st_t ack_next;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic scl_d;
		logic sda_d;
		logic tick_d;
		logic pin_oe;
		logic alert_oe;
		logic zero;
		logic seq_en;
		logic periodic_en;
		logic single;
		logic [2:0] rate;
		logic [7:0] int_ctl;
		logic [15:0] thr_lo;
		logic [15:0] thr_up;
		logic [15:0] result;
		logic valid;
		logic [7:0] stat;
		logic busy;
		logic start;
		logic [7:0] run_cnt;
	} pmic_ctrl_state_t;

	pmic_ctrl_state_t s_reg;
	pmic_ctrl_state_t s_next;

	logic [2:0] pins;
	logic tick_tgl;
	logic scl_s;
	logic sda_s;
	logic tick_s;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic wr_stb;
	logic rd_stb;
	logic [7:0] rd_byte;
	logic tick;
	logic hit_up;
	logic hit_lo;

	// ----------------------------------------------------------------
	// crossings and low-power timer
	// ----------------------------------------------------------------
	pmic_sync #(.W(3)) u_pin_sync (
		.clk(sys_clk),
		.d({tick_tgl, sda_i, scl_i}),
		.q(pins)
	);

	pmic_rate_timer #(.LP_BASE_CYCLES(LP_BASE_CYCLES)) u_timer (
		.lp_clk(lp_clk),
		.rst(rst),
		.seq_en(s_reg.seq_en),
		.periodic_en(s_reg.periodic_en),
		.rate(s_reg.rate),
		.tick_tgl(tick_tgl)
	);

	assign scl_s = pins[0];
	assign sda_s = pins[1];
	assign tick_s = pins[2];
	assign scl_rise = scl_s & ~s_reg.scl_d;
	assign scl_fall = ~scl_s & s_reg.scl_d;
	assign bus_start = scl_s & s_reg.scl_d & s_reg.sda_d & ~sda_s;
	assign bus_stop = scl_s & s_reg.scl_d & ~s_reg.sda_d & sda_s;
	assign tick = tick_s ^ s_reg.tick_d;
	// RULE_01: limit comparison
	assign hit_up = conv_data > s_reg.thr_up;
	assign hit_lo = conv_data < s_reg.thr_lo;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// RULE_05: per-condition enables
	function automatic logic [7:0] flag_mask(input logic [7:0] ctl);
		flag_mask = 8'h00;
		flag_mask[pmic_pkg::STAT_UPPER] = ctl[pmic_pkg::ICTL_THR_EN];
		flag_mask[pmic_pkg::STAT_LOWER] = ctl[pmic_pkg::ICTL_THR_EN];
		flag_mask[pmic_pkg::STAT_READY] = ctl[pmic_pkg::ICTL_RDY_EN];
	endfunction

	// count code n selects a run of 2**n, 1 to 128
	function automatic logic [7:0] run_target(input logic [7:0] ctl);
		run_target = 8'(9'h001 << ctl[pmic_pkg::ICTL_COUNT_LSB +: 3]);
	endfunction

	function automatic logic [7:0] reg_read(input pmic_ctrl_state_t q, input logic [7:0] a);
		reg_read = 8'h00;
		case (a)
			pmic_pkg::REG_CMD:
			begin
				// RULE_10: command readback, frozen bit fixed high
				reg_read[pmic_pkg::CMD_FROZEN] = 1'b1;
				reg_read[pmic_pkg::CMD_RESULT_VALID] = q.valid;
				reg_read[pmic_pkg::CMD_SINGLE_SHOT] = q.single;
				reg_read[pmic_pkg::CMD_PERIODIC_EN] = q.periodic_en;
				reg_read[pmic_pkg::CMD_SEQ_EN] = q.seq_en;
			end
			pmic_pkg::REG_RATE: reg_read = {5'h00, q.rate};
			pmic_pkg::REG_RES_HI: reg_read = q.result[15:8];
			pmic_pkg::REG_RES_LO: reg_read = q.result[7:0];
			pmic_pkg::REG_INT_CTL: reg_read = q.int_ctl;
			pmic_pkg::REG_THR_LO_HI: reg_read = q.thr_lo[15:8];
			pmic_pkg::REG_THR_LO_LO: reg_read = q.thr_lo[7:0];
			pmic_pkg::REG_THR_UP_HI: reg_read = q.thr_up[15:8];
			pmic_pkg::REG_THR_UP_LO: reg_read = q.thr_up[7:0];
			// RULE_07: latched flags readable
			pmic_pkg::REG_INT_STAT: reg_read = q.stat;
			default: reg_read = 8'h00;
		endcase
	endfunction

	assign rd_byte = reg_read(s_reg, s_reg.ptr);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_next = s_reg;
		s_next.start = 1'b0;
		s_next.scl_d = scl_s;
		s_next.sda_d = sda_s;
		s_next.tick_d = tick_s;
		wr_stb = 1'b0;
		rd_stb = 1'b0;

		// serial slave: sample on rising clock, drive on falling clock
		if (bus_start)
		begin
			s_next.st = pmic_pkg::SL_ADDR;
			s_next.cnt = 4'h0;
			s_next.pin_oe = 1'b0;
		end
		else if (bus_stop)
		begin
			s_next.st = pmic_pkg::SL_IDLE;
			s_next.pin_oe = 1'b0;
		end
		else if (scl_rise)
		begin
			case (s_reg.st)
				pmic_pkg::SL_ADDR, pmic_pkg::SL_SUB, pmic_pkg::SL_WDATA:
				begin
					s_next.sh = {s_reg.sh[6:0], sda_s};
					s_next.cnt = s_reg.cnt + 4'h1;
				end
				pmic_pkg::SL_READ:
				begin
					s_next.sh = {s_reg.sh[6:0], 1'b0};
					s_next.cnt = s_reg.cnt + 4'h1;
				end
				pmic_pkg::SL_RACK:
				begin
					if (sda_s)
						s_next.st = pmic_pkg::SL_IDLE;
				end
				default: ;
			endcase
		end
		else if (scl_fall)
		begin
			case (s_reg.st)
				pmic_pkg::SL_ADDR:
				begin
					if (s_reg.cnt == 4'h8)
					begin
						if (s_reg.sh[7:1] == DEV_ADDR)
						begin
							s_next.pin_oe = 1'b1;
							s_next.st = pmic_pkg::SL_ACK;
							s_next.ack_next = s_reg.sh[0] ? pmic_pkg::SL_READ : pmic_pkg::SL_SUB;
						end
						else
							s_next.st = pmic_pkg::SL_IDLE;
					end
				end
				pmic_pkg::SL_SUB:
				begin
					if (s_reg.cnt == 4'h8)
					begin
						s_next.ptr = s_reg.sh;
						s_next.pin_oe = 1'b1;
						s_next.st = pmic_pkg::SL_ACK;
						s_next.ack_next = pmic_pkg::SL_WDATA;
					end
				end
				pmic_pkg::SL_WDATA:
				begin
					if (s_reg.cnt == 4'h8)
					begin
						wr_stb = 1'b1;
						s_next.ptr = s_reg.ptr + 8'h01;
						s_next.pin_oe = 1'b1;
						s_next.st = pmic_pkg::SL_ACK;
						s_next.ack_next = pmic_pkg::SL_WDATA;
					end
				end
				pmic_pkg::SL_ACK:
				begin
					s_next.cnt = 4'h0;
					s_next.st = s_reg.ack_next;
					s_next.pin_oe = 1'b0;
					if (s_reg.ack_next == pmic_pkg::SL_READ)
					begin
						rd_stb = 1'b1;
						s_next.sh = rd_byte;
						s_next.pin_oe = ~rd_byte[7];
						s_next.ptr = s_reg.ptr + 8'h01;
					end
				end
				pmic_pkg::SL_READ:
				begin
					if (s_reg.cnt == 4'h8)
					begin
						s_next.pin_oe = 1'b0;
						s_next.st = pmic_pkg::SL_RACK;
					end
					else
						s_next.pin_oe = ~s_reg.sh[7];
				end
				pmic_pkg::SL_RACK:
				begin
					rd_stb = 1'b1;
					s_next.sh = rd_byte;
					s_next.pin_oe = ~rd_byte[7];
					s_next.ptr = s_reg.ptr + 8'h01;
					s_next.cnt = 4'h0;
					s_next.st = pmic_pkg::SL_READ;
				end
				default: ;
			endcase
		end

		// register writes
		if (wr_stb)
		begin
			case (s_reg.ptr)
				pmic_pkg::REG_CMD:
				begin
					s_next.seq_en = s_reg.sh[pmic_pkg::CMD_SEQ_EN];
					s_next.periodic_en = s_reg.sh[pmic_pkg::CMD_PERIODIC_EN];
					// RULE_16: single shot refused under sequencer
					if (s_reg.sh[pmic_pkg::CMD_SINGLE_SHOT] && !s_reg.seq_en
						&& !s_reg.sh[pmic_pkg::CMD_SEQ_EN])
						s_next.single = 1'b1;
				end
				pmic_pkg::REG_RATE:
				begin
					// RULE_17: rate frozen while sequencing
					if (!s_reg.seq_en)
						s_next.rate = s_reg.sh[2:0];
				end
				pmic_pkg::REG_INT_CTL: s_next.int_ctl = s_reg.sh;
				pmic_pkg::REG_THR_LO_HI: s_next.thr_lo[15:8] = s_reg.sh;
				pmic_pkg::REG_THR_LO_LO: s_next.thr_lo[7:0] = s_reg.sh;
				pmic_pkg::REG_THR_UP_HI: s_next.thr_up[15:8] = s_reg.sh;
				pmic_pkg::REG_THR_UP_LO: s_next.thr_up[7:0] = s_reg.sh;
				// RULE_08: write one clears that flag only
				// RULE_09: all ones clears every flag
				pmic_pkg::REG_INT_STAT: s_next.stat = s_reg.stat & ~s_reg.sh;
				default: ;
			endcase
		end

		// RULE_11: reading either result byte clears valid
		if (rd_stb && (s_reg.ptr == pmic_pkg::REG_RES_HI || s_reg.ptr == pmic_pkg::REG_RES_LO))
			s_next.valid = 1'b0;

		// measurement completion; sets below win over the clears above
		if (s_reg.busy && conv_done)
		begin
			// RULE_12: result bytes stored at end of conversion
			s_next.result = conv_data;
			s_next.busy = 1'b0;
			s_next.single = 1'b0;
			s_next.valid = 1'b1;
			// RULE_04: data ready event
			// RULE_06: each flag latched independently
			if (s_reg.int_ctl[pmic_pkg::ICTL_RDY_EN])
				s_next.stat[pmic_pkg::STAT_READY] = 1'b1;
			// RULE_18: failed measurement restarts the run
			if (!(hit_up || hit_lo))
				s_next.run_cnt = 8'h00;
			else if (s_reg.run_cnt != 8'hff)
				s_next.run_cnt = s_reg.run_cnt + 8'h01;
			// RULE_03: event only after the consecutive run
			if ((hit_up || hit_lo) && s_next.run_cnt >= run_target(s_reg.int_ctl)
				&& s_reg.int_ctl[pmic_pkg::ICTL_THR_EN])
			begin
				if (hit_up)
					s_next.stat[pmic_pkg::STAT_UPPER] = 1'b1;
				if (hit_lo)
					s_next.stat[pmic_pkg::STAT_LOWER] = 1'b1;
			end
		end

		// RULE_16: a pending single shot dies when sequencing starts
		if (s_next.seq_en)
			s_next.single = 1'b0;
		// RULE_14: periodic start needs both enables
		if (!s_reg.busy && (s_next.single || (tick && s_reg.seq_en && s_reg.periodic_en)))
		begin
			s_next.start = 1'b1;
			s_next.busy = 1'b1;
		end

		// RULE_19: alert held while any enabled flag set
		// RULE_02: pull-down only
		s_next.alert_oe = |(s_next.stat & flag_mask(s_next.int_ctl));
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_reg <= '0;
			s_reg.st <= pmic_pkg::SL_IDLE;
			s_reg.ack_next <= pmic_pkg::SL_IDLE;
			s_reg.scl_d <= 1'b1;
			s_reg.sda_d <= 1'b1;
			s_reg.rate <= pmic_pkg::RATE_RST;
			s_reg.int_ctl <= pmic_pkg::INT_CTL_RST;
			s_reg.thr_lo <= pmic_pkg::THR_LO_RST;
			s_reg.thr_up <= pmic_pkg::THR_UP_RST;
		end
		else
			s_reg <= s_next;
	end

	assign sda_o = s_reg.zero;
	assign sda_oe = s_reg.pin_oe;
	assign int_n_o = s_reg.zero;
	assign int_n_oe = s_reg.alert_oe;
	assign conv_start = s_reg.start;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_pins_never_high: assert property (!sda_o && !int_n_o) // RULE_02
		else $error("open drain pin driven high");
	a_ready_flag_alert: assert property (s_reg.busy && conv_done // RULE_04
		&& s_reg.int_ctl[pmic_pkg::ICTL_RDY_EN] |=> s_reg.stat[pmic_pkg::STAT_READY] && int_n_oe)
		else $error("ready event did not set flag and alert");
	a_upper_single_hit: assert property (s_reg.busy && conv_done && hit_up // RULE_01
		&& s_reg.int_ctl[pmic_pkg::ICTL_THR_EN] && run_target(s_reg.int_ctl) == 8'h01
		|=> s_reg.stat[pmic_pkg::STAT_UPPER])
		else $error("upper limit hit not flagged");
	a_run_reset_miss: assert property (s_reg.busy && conv_done && !hit_up && !hit_lo // RULE_18
		|=> s_reg.run_cnt == 8'h00)
		else $error("run counter not cleared by a miss");
	a_filter_holds_off: assert property (s_reg.busy && conv_done // RULE_03
		&& {1'b0, s_reg.run_cnt} + 9'h001 < {1'b0, run_target(s_reg.int_ctl)}
		&& !s_reg.stat[pmic_pkg::STAT_UPPER]
		&& !(wr_stb && s_reg.ptr == pmic_pkg::REG_INT_STAT) |=> !s_reg.stat[pmic_pkg::STAT_UPPER])
		else $error("threshold flag before run complete");
	a_clear_all_ones: assert property (wr_stb && s_reg.ptr == pmic_pkg::REG_INT_STAT // RULE_09
		&& s_reg.sh == 8'hff && !(s_reg.busy && conv_done) |=> s_reg.stat == 8'h00 && !int_n_oe)
		else $error("all-ones write left flags or alert");
	a_alert_release: assert property ($fell(int_n_oe) |-> $past(wr_stb) // RULE_19
		|| $past(wr_stb, 1) == 1'b0 && $past(s_reg.int_ctl) != s_reg.int_ctl)
		else $error("alert released without host write");
	a_valid_read_clr: assert property (rd_stb && s_reg.ptr == pmic_pkg::REG_RES_LO // RULE_11
		&& !(s_reg.busy && conv_done) |=> !s_reg.valid)
		else $error("result read did not clear valid");
	a_rate_locked: assert property (wr_stb && s_reg.ptr == pmic_pkg::REG_RATE // RULE_17
		&& s_reg.seq_en |=> $stable(s_reg.rate))
		else $error("rate changed while sequencing");
	a_no_single_seq: assert property (s_reg.seq_en && !s_reg.periodic_en && !s_reg.busy // RULE_16
		|=> !conv_start ##1 !conv_start)
		else $error("conversion started with sequencer idle");

	c_single_shot: cover property (!s_reg.seq_en && conv_start ##[1:200] conv_done);
	c_periodic_run: cover property (s_reg.seq_en && s_reg.periodic_en && conv_start);
	c_two_flags: cover property (s_reg.stat[pmic_pkg::STAT_UPPER] && s_reg.stat[pmic_pkg::STAT_READY]);

endmodule // pmic_ctrl

//--- test/pmic_host_model.sv
// host side model: bit-level serial bus master used for register access
module pmic_host_model #(
	parameter logic [6:0] DEV = 7'h2a
) (
	// clock
	input wire logic sys_clk,
	// bus pins, sda_low high pulls the data wire down
	output logic scl,
	output logic sda_low,
	input wire logic sda_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// one phase in clocks; the low half of scl spans two phases
	localparam int PH = 6;

	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic set_pins(input logic c, input logic d_low);
		@(posedge sys_clk);
		scl <= c;
		sda_low <= d_low;
		repeat (PH - 1) @(posedge sys_clk);
	endtask

	// scl falls first so a device still acking has let go before sda drops
	task automatic start();
		set_pins(1'b0, 1'b0);
		set_pins(1'b1, 1'b0);
		set_pins(1'b1, 1'b1);
		set_pins(1'b0, 1'b1);
	endtask

	task automatic stop();
		set_pins(1'b0, 1'b1);
		set_pins(1'b1, 1'b1);
		set_pins(1'b1, 1'b0);
	endtask

	// data only moves while scl is low, one phase after the fall
	task automatic tx_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			set_pins(1'b0, sda_low);
			set_pins(1'b0, ~b[i]);
			set_pins(1'b1, ~b[i]);
		end
		set_pins(1'b0, sda_low);
		set_pins(1'b0, 1'b0);
		set_pins(1'b1, 1'b0);
		ack = ~sda_line;
	endtask

	task automatic rx_byte(input logic nack, output logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			set_pins(1'b0, 1'b0);
			set_pins(1'b0, 1'b0);
			set_pins(1'b1, 1'b0);
			b[i] = sda_line;
		end
		set_pins(1'b0, 1'b0);
		set_pins(1'b0, ~nack);
		set_pins(1'b1, ~nack);
	endtask

	task automatic reg_write(input logic [7:0] sub, input logic [7:0] d, output logic ok);
		logic a0;
		logic a1;
		logic a2;
		start();
		tx_byte({DEV, 1'b0}, a0);
		tx_byte(sub, a1);
		tx_byte(d, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask

	task automatic reg_read(input logic [7:0] sub, output logic [7:0] d);
		logic a;
		start();
		tx_byte({DEV, 1'b0}, a);
		tx_byte(sub, a);
		start();
		tx_byte({DEV, 1'b1}, a);
		rx_byte(1'b1, d);
		stop();
	endtask
endmodule // pmic_host_model

//--- test/testbench.sv
// self-checking bench for the measurement control and alert block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, lp_clk, rst, scl, sda_low, sda_o, sda_oe, int_n_o, int_n_oe;
	logic conv_start, conv_done, ack;
	logic [15:0] conv_data, conv_val;
	logic [7:0] rv;
	wire sda_line = (sda_oe ? sda_o : 1'b1) & ~sda_low;
	wire int_line = int_n_oe ? int_n_o : 1'b1;
	int starts, dones, conv_wait, cycles, bad_count, comparisons, n;

	pmic_ctrl #(.LP_BASE_CYCLES(32'h0000_0004)) u_pmic_ctrl (.sys_clk(sys_clk), .rst(rst),
		.lp_clk(lp_clk), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
		.int_n_o(int_n_o), .int_n_oe(int_n_oe), .conv_start(conv_start),
		.conv_done(conv_done), .conv_data(conv_data));
	pmic_host_model #(.DEV(pmic_pkg::DEV_ADDR_RST)) u_pmic_host_model (.sys_clk(sys_clk),
		.scl(scl), .sda_low(sda_low), .sda_line(sda_line));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial
	begin
		lp_clk = 1'b0;
		#7;
		forever #15 lp_clk = ~lp_clk;
	end

	// --------------------------------------------------------------
	// converter stand-in: done five clocks after each start
	// --------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		conv_done <= 1'b0;
		conv_data <= ~conv_val;
		if (conv_start)
		begin
			starts <= starts + 1;
			conv_wait <= 5;
		end
		else if (conv_wait != 0)
		begin
			conv_wait <= conv_wait - 1;
			if (conv_wait == 1)
			begin
				conv_done <= 1'b1;
				conv_data <= conv_val;
				dones <= dones + 1;
			end
		end
	end

	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 90000)
		begin
			bad_count++;
			results();
		end
	end

	task automatic results();
		if (bad_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] sub, input logic [7:0] d);
		u_pmic_host_model.reg_write(sub, d, ack);
		chk("write ack", 8'h01, {7'h00, ack});
	endtask

	task automatic rd(input string nm, input logic [7:0] sub, input logic [7:0] exp);
		u_pmic_host_model.reg_read(sub, rv);
		chk(nm, exp, rv);
	endtask

	task automatic alert(input logic exp);
		chk("alert pin", {7'h00, exp}, {7'h00, int_line});
	endtask

	// one on-demand conversion, waited for under a bound
	task automatic measure(input logic [15:0] v);
		int n0;
		n0 = dones;
		conv_val = v;
		wr(pmic_pkg::REG_CMD, 8'h08);
		for (int i = 0; i < 100 && dones == n0; i++) @(posedge sys_clk);
		repeat (3) @(posedge sys_clk);
		chk("conversion", 8'h01, {7'h00, dones != n0});
	endtask

	initial
	begin
		rst = 1'b1;
		conv_val = 16'h0000;
		{starts, dones, conv_wait, cycles, bad_count, comparisons} = '0;
		// long enough for the slow oscillator domain to see it too
		repeat (13) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (5) @(posedge sys_clk);
		rd("cmd", pmic_pkg::REG_CMD, 8'h80);
		rd("int ctl", pmic_pkg::REG_INT_CTL, 8'h00);
		rd("upper hi", pmic_pkg::REG_THR_UP_HI, 8'hff);
		rd("unmapped", 8'h90, 8'h00);
		alert(1'b1);
		u_pmic_host_model.start();
		u_pmic_host_model.tx_byte({~pmic_pkg::DEV_ADDR_RST, 1'b0}, ack);
		u_pmic_host_model.stop();
		chk("foreign addr", 8'h00, {7'h00, ack});
		// --------------------------------------------------------------
		// single shot with ready alert
		// --------------------------------------------------------------
		wr(pmic_pkg::REG_INT_CTL, 8'h08);
		measure(16'h1234);
		alert(1'b0);
		rd("cmd valid", pmic_pkg::REG_CMD, 8'ha0);
		rd("status", pmic_pkg::REG_INT_STAT, 8'h08);
		rd("res hi", pmic_pkg::REG_RES_HI, 8'h12);
		rd("res lo", pmic_pkg::REG_RES_LO, 8'h34);
		rd("cmd read", pmic_pkg::REG_CMD, 8'h80);
		wr(pmic_pkg::REG_INT_STAT, 8'h08);
		alert(1'b1);
		// --------------------------------------------------------------
		// thresholds, upper limit with a run of two, lower limit with a run of one
		// --------------------------------------------------------------
		wr(pmic_pkg::REG_THR_UP_HI, 8'h10);
		wr(pmic_pkg::REG_THR_UP_LO, 8'h00);
		wr(pmic_pkg::REG_INT_CTL, 8'h22);
		measure(16'h2000);
		rd("one hit", pmic_pkg::REG_INT_STAT, 8'h00);
		measure(16'h0800);
		measure(16'h2000);
		rd("broken run", pmic_pkg::REG_INT_STAT, 8'h00);
		measure(16'h2000);
		rd("upper", pmic_pkg::REG_INT_STAT, 8'h01);
		wr(pmic_pkg::REG_THR_LO_LO, 8'h40);
		wr(pmic_pkg::REG_INT_CTL, 8'h02);
		measure(16'h0010);
		rd("lower", pmic_pkg::REG_INT_STAT, 8'h03);
		wr(pmic_pkg::REG_INT_STAT, 8'h01);
		rd("one cleared", pmic_pkg::REG_INT_STAT, 8'h02);
		alert(1'b0);
		wr(pmic_pkg::REG_INT_STAT, 8'hff);
		rd("all cleared", pmic_pkg::REG_INT_STAT, 8'h00);
		alert(1'b1);
		// --------------------------------------------------------------
		// simultaneous events and enable gating
		// --------------------------------------------------------------
		wr(pmic_pkg::REG_INT_CTL, 8'h0a);
		measure(16'hf000);
		rd("both", pmic_pkg::REG_INT_STAT, 8'h09);
		wr(pmic_pkg::REG_INT_CTL, 8'h00);
		alert(1'b1);
		wr(pmic_pkg::REG_INT_STAT, 8'hff);
		measure(16'hf000);
		rd("masked", pmic_pkg::REG_INT_STAT, 8'h00);
		// --------------------------------------------------------------
		// self-timed operation
		// --------------------------------------------------------------
		wr(pmic_pkg::REG_RATE, 8'h07);
		rd("rate", pmic_pkg::REG_RATE, 8'h07);
		wr(pmic_pkg::REG_CMD, 8'h01);
		wr(pmic_pkg::REG_RATE, 8'h00);
		rd("rate locked", pmic_pkg::REG_RATE, 8'h07);
		n = starts;
		wr(pmic_pkg::REG_CMD, 8'h09);
		repeat (300) @(posedge sys_clk);
		chk("idle seq", 8'h00, 8'(starts - n));
		wr(pmic_pkg::REG_CMD, 8'h03);
		repeat (300) @(posedge sys_clk);
		chk("periodic", 8'h01, {7'h00, (starts - n) >= 2});
		wr(pmic_pkg::REG_CMD, 8'h00);
		results();
	end
endmodule // testbench
